// ==== core/hpm_device.sv ====
`timescale 1ns/10ps
// What this block does
// [R1] all pins may be gpio while port off
// [R2] unused pins may be gpio while port on
// [R3] gpio pins give host logic fixed values
// [R4] each pin has enable, direction, data bits; here the enable is one gp_enable_i bit per pin group
// [R5] enables reset to zero, host function kept
// [R6] enable set hands pin to gpio bits
// [R7] strobe gpio gives host logic constant one
// [R8] direction one drives, zero listens
// [R9] output pin drives written data, reads back
// [R10] input pin ignores writes, reads pin level
// [R11] switching to output drives last sample
// [R12] strobe input feeds cpu irq and dma
// [R13] event enable gates forwarded strobe level
// [R14] event invert flips forwarded strobe level
// [R15] cpu irq controller acts on rising edge
// [R16] dma acts on programmable either edge
// [R17] port stays off until configured, enabled
// [R18] software writes mode bits with enable zero
// [R19] page registers loaded before enabling
// [R20] enable set, mode kept, then soft reset cleared
// [R21] port answers host once soft reset clears
// [R22] host writes control, then address, then data
// [R23] input pins keep output driver off
module hpm_device (
	input wire logic core_clk_i, // core clock
	input wire logic reset_n_i, // sync reset, active low
	input wire logic ce_i, // clock enable
	hpm_link_if.dev link, // pins toward the host
	input wire logic port_enable_bit_i, // port on bit of config reg
	input wire logic byte_addressing_bit_i, // byte addressing mode
	input wire logic nonmuxed_mode_bit_i, // non-multiplexed mode
	input wire logic page_restrict_bit_i, // page restriction mode
	input wire logic [hpm_pkg::PAGE_W-1:0] page_addr_high_byte_i, // page bits 23:16
	input wire logic [hpm_pkg::PAGE_W-1:0] page_addr_upper_byte_i, // page bits 31:24
	input wire logic port_soft_reset_i, // soft reset, high holds port
	input wire logic [hpm_pkg::GRP_N-1:0] gp_enable_i, // per-group gpio enable
	input wire logic [hpm_pkg::PIN_N-1:0] pin_direction_i, // per-pin direction
	input wire logic [hpm_pkg::PIN_N-1:0] pin_data_wr_i, // per-pin data write strobe
	input wire logic [hpm_pkg::PIN_N-1:0] pin_data_wdata_i, // per-pin data write value
	input wire logic strobe_event_enable_i, // forward strobe to events
	input wire logic strobe_event_invert_i, // invert forwarded strobe
	input wire logic hif_rd_drive_i, // host logic drives data lines
	input wire logic [hpm_pkg::DAT_W-1:0] hif_rd_data_i, // host logic read data
	output logic [hpm_pkg::PIN_N-1:0] pin_data_value_o, // per-pin data read value
	output logic [hpm_pkg::PIN_N-1:0] hif_pins_o, // pin view of host logic
	output logic hif_active_o, // host logic may answer host
	output logic hif_byte_addr_o, // latched byte addressing
	output logic hif_nonmux_o, // latched non-multiplexed mode
	output logic hif_page_restrict_o, // latched page restriction
	output logic [2*hpm_pkg::PAGE_W-1:0] hif_page_o, // latched page address
	output logic cfg_error_o, // mode bits changed while on
	output logic cpu_irq_line_six_o, // cpu interrupt level
	output logic dma_event_o // dma event level
);
	import hpm_pkg::*;

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------

	// pin index to gpio enable group
	function automatic int unsigned pin_group(input int unsigned p);
		int unsigned g;
		g = GRP_CTL;
		if (p == STB_BIT) begin
			g = GRP_STROBE;
		end else if (p >= BE_LSB && p < DAT_LSB) begin
			g = GRP_BE;
		end else if (p >= DAT_LSB && p < ADR_LSB) begin
			g = GRP_DAT0 + (p - DAT_LSB) / GRP_PINS;
		end else if (p >= ADR_LSB) begin
			g = GRP_ADR0 + (p - ADR_LSB) / GRP_PINS;
		end
		return g;
	endfunction

	// ------------------------------------------------------------
	// per-pin gpio cells
	// ------------------------------------------------------------
	logic [PIN_N-1:0] pin_sync;
	logic [PIN_N-1:0] pin_dat;
	logic [PIN_N-1:0] gp_req;

	// direction and data bits per pin, enable shared by its group
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			// [R4] enable direction data
			assign gp_req[gi] = gp_enable_i[pin_group(gi)];
			hpm_gpio_cell u_cell (
				.core_clk_i(core_clk_i),
				.reset_n_i(reset_n_i),
				.ce_i(ce_i),
				.pin_i(link.pin[gi]),
				.dir_i(pin_direction_i[gi]),
				.wr_i(pin_data_wr_i[gi]),
				.wdata_i(pin_data_wdata_i[gi]),
				.pin_sync_o(pin_sync[gi]),
				.dat_o(pin_dat[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// configuration latch
	// ------------------------------------------------------------
	logic port_on_r;
	logic byte_addr_r;
	logic nonmux_r;
	logic page_restrict_r;
	logic [2*PAGE_W-1:0] page_r;
	logic mode_change;
	logic cfg_load;

	// mode and page bits are taken only while the port is off
	assign cfg_load = !port_on_r;
	// [R20] mode kept on enable
	assign mode_change = port_on_r && port_enable_bit_i &&
		((byte_addressing_bit_i != byte_addr_r) || (nonmuxed_mode_bit_i != nonmux_r) ||
		(page_restrict_bit_i != page_restrict_r));

	// [R18] mode set while off
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			port_on_r <= 1'b0;
			byte_addr_r <= 1'b0;
			nonmux_r <= 1'b0;
			page_restrict_r <= 1'b0;
			page_r <= {PAGE_RESET, PAGE_RESET};
		end else if (ce_i) begin
			port_on_r <= port_enable_bit_i;
			if (cfg_load) begin
				byte_addr_r <= byte_addressing_bit_i;
				nonmux_r <= nonmuxed_mode_bit_i;
				page_restrict_r <= page_restrict_bit_i;
				// [R19] page loaded before enable
				page_r <= {page_addr_upper_byte_i, page_addr_high_byte_i};
			end
		end
	end

	// ------------------------------------------------------------
	// pin ownership
	// ------------------------------------------------------------
	logic [PIN_N-1:0] gp_allow;
	logic [PIN_N-1:0] gp_eff;
	logic [PIN_N-1:0] hif_nxt;
	logic [PIN_N-1:0] oe_nxt;
	logic [PIN_N-1:0] out_nxt;
	logic [PIN_N-1:0] rd_data_pins;
	logic active_nxt;

	// [R1] any pin while port off
	// [R2] unused pins while port on
	assign gp_allow = port_on_r ? (OPT_MASK | (nonmux_r ? '0 : ADR_MASK)) : {PIN_N{1'b1}};
	// [R5] enables zero keep host function
	// [R6] enable hands pin over
	assign gp_eff = gp_req & gp_allow;

	// [R3] gpio pins seen as defaults
	// [R7] strobe seen as one
	assign hif_nxt = (pin_sync & ~gp_eff) | (HIF_DEFAULT & gp_eff);

	// [R17] held until enabled
	// [R21] answers after soft reset clears
	assign active_nxt = port_on_r && !port_soft_reset_i;

	assign rd_data_pins = {{ADR_W{1'b0}}, hif_rd_data_i, {DAT_LSB{1'b0}}};

	// [R8] direction picks driver
	// [R23] inputs leave driver off
	assign oe_nxt = (gp_eff & pin_direction_i) |
		(~gp_eff & DAT_MASK & {PIN_N{hif_rd_drive_i && active_nxt}});
	// [R9] output drives data bit
	// [R11] data bit holds last sample
	assign out_nxt = (gp_eff & pin_dat) | (~gp_eff & rd_data_pins);

	// ------------------------------------------------------------
	// strobe events
	// ------------------------------------------------------------
	logic strobe_in;
	logic event_nxt;

	// [R12] strobe as gpio input
	assign strobe_in = gp_eff[STB_BIT] && !pin_direction_i[STB_BIT];
	// [R13] enable gates level
	// [R14] invert flips level
	assign event_nxt = strobe_in && strobe_event_enable_i &&
		(pin_sync[STB_BIT] ^ strobe_event_invert_i);

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	logic [PIN_N-1:0] hif_r;
	logic [PIN_N-1:0] oe_r;
	logic [PIN_N-1:0] out_r;
	logic active_r;
	logic cfg_err_r;
	logic event_r;

	// pin drive, host view and event levels
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			hif_r <= HIF_DEFAULT;
			oe_r <= PIN_RESET;
			out_r <= PIN_RESET;
			active_r <= 1'b0;
			cfg_err_r <= 1'b0;
			event_r <= 1'b0;
		end else if (ce_i) begin
			hif_r <= hif_nxt;
			oe_r <= oe_nxt;
			out_r <= out_nxt;
			active_r <= active_nxt;
			cfg_err_r <= mode_change;
			// [R15] level only, edge found downstream
			event_r <= event_nxt;
		end
	end

	// one level serves both consumers, they pick their own edge
	assign link.dev_o = out_r;
	assign link.dev_oe = oe_r;
	// [R10] input reads pin level
	assign pin_data_value_o = pin_dat;
	assign hif_pins_o = hif_r;
	assign hif_active_o = active_r;
	assign hif_byte_addr_o = byte_addr_r;
	assign hif_nonmux_o = nonmux_r;
	assign hif_page_restrict_o = page_restrict_r;
	assign hif_page_o = page_r;
	assign cfg_error_o = cfg_err_r;
	assign cpu_irq_line_six_o = event_r;
	// [R16] dma chooses its edge
	assign dma_event_o = event_r;

endmodule

// ==== core/hpm_gpio_cell.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// one pin: input synchroniser and gpio data bit
// ------------------------------------------------------------
module hpm_gpio_cell (
	input wire logic core_clk_i, // core clock
	input wire logic reset_n_i, // sync reset, active low
	input wire logic ce_i, // clock enable
	input wire logic pin_i, // raw pin level
	input wire logic dir_i, // 1 output, 0 input
	input wire logic wr_i, // data bit write strobe
	input wire logic wdata_i, // data bit write value
	output logic pin_sync_o, // synchronised pin level
	output logic dat_o // data bit read value
);
	import hpm_pkg::*;

	logic meta_r;
	logic sync_r;
	logic dat_r;
	logic dat_nxt;

	// output keeps last write, input tracks the sampled pin
	assign dat_nxt = dir_i ? (wr_i ? wdata_i : dat_r) : sync_r;
	assign pin_sync_o = sync_r;
	assign dat_o = dat_r;

	// two-flop synchroniser and data bit
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			dat_r <= 1'b0;
		end else if (ce_i) begin
			meta_r <= pin_i;
			sync_r <= meta_r;
			dat_r <= dat_nxt;
		end
	end

endmodule

// ==== core/hpm_host.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// external host end: drives register accesses over the pins
// ------------------------------------------------------------
module hpm_host (
	input wire logic core_clk_i, // core clock
	input wire logic reset_n_i, // sync reset, active low
	input wire logic ce_i, // clock enable
	hpm_link_if.host link, // pins toward the device
	input wire logic req_i, // access request pulse
	input wire logic req_write_i, // 1 write, 0 read
	input wire logic [hpm_pkg::CTL_W-1:0] req_ctl_i, // register select code
	input wire logic [hpm_pkg::BE_W-1:0] req_be_i, // byte enables, active high
	input wire logic [hpm_pkg::DAT_W-1:0] req_wdata_i, // write data
	input wire logic [hpm_pkg::ADR_W-1:0] req_addr_i, // address lines value
	output logic busy_o, // access in progress
	output logic done_o, // access finished pulse
	output logic refused_o, // request out of order pulse
	output logic ready_o, // control and address written
	output logic [hpm_pkg::DAT_W-1:0] rd_data_o // last read data
);
	import hpm_pkg::*;

	typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_DONE} hpm_hstate_e;

	hpm_hstate_e state_r;
	hpm_hstate_e state_nxt;
	logic [2:0] cnt_r;
	logic ctl_done_r;
	logic addr_done_r;
	logic wr_r;
	logic [CTL_W-1:0] ctl_r;
	logic [PIN_N-1:0] out_r;
	logic [PIN_N-1:0] oe_r;
	logic [DAT_W-1:0] meta_r;
	logic [DAT_W-1:0] sync_r;
	logic [DAT_W-1:0] rd_r;
	logic done_r;
	logic refused_r;
	logic order_ok;
	logic take;
	logic [PIN_N-1:0] setup_out;
	logic [PIN_N-1:0] setup_oe;

	// [R22] control first, address next, data last
	assign order_ok = (req_ctl_i == HCTL_CTRL) || (req_ctl_i == HCTL_ADDR && ctl_done_r) ||
		(ctl_done_r && addr_done_r);
	assign take = (state_r == HS_IDLE) && req_i;

	// pin values for an access, strobe idle high, byte enables active low
	assign setup_out = {req_addr_i, req_wdata_i, ~req_be_i, 1'b1, req_ctl_i};
	assign setup_oe = {{ADR_W{1'b1}}, {DAT_W{req_write_i}}, {BE_W{1'b1}}, 3'h7};

	// access sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			HS_IDLE: begin
				if (take && order_ok) begin
					state_nxt = HS_SETUP;
				end
			end
			HS_SETUP: state_nxt = HS_STROBE;
			HS_STROBE: begin
				if (cnt_r == STROBE_LAST) begin
					state_nxt = HS_DONE;
				end
			end
			HS_DONE: state_nxt = HS_IDLE;
		endcase
	end

	// state, pins and order flags
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state_r <= HS_IDLE;
			cnt_r <= 3'h0;
			ctl_done_r <= 1'b0;
			addr_done_r <= 1'b0;
			wr_r <= 1'b0;
			ctl_r <= HCTL_CTRL;
			out_r <= {PIN_N{1'b1}};
			oe_r <= PIN_RESET;
			meta_r <= '0;
			sync_r <= '0;
			rd_r <= '0;
			done_r <= 1'b0;
			refused_r <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			meta_r <= link.pin[DAT_LSB +: DAT_W];
			sync_r <= meta_r;
			done_r <= (state_r == HS_DONE);
			refused_r <= take && !order_ok;
			cnt_r <= (state_r == HS_STROBE) ? cnt_r + 3'h1 : 3'h0;
			if (take && order_ok) begin
				out_r <= setup_out;
				oe_r <= setup_oe;
				wr_r <= req_write_i;
				ctl_r <= req_ctl_i;
			end
			out_r[STB_BIT] <= !(state_nxt == HS_STROBE);
			if (state_r == HS_DONE) begin
				oe_r <= PIN_RESET;
				if (!wr_r) begin
					rd_r <= sync_r;
				end
				if (wr_r && ctl_r == HCTL_CTRL) begin
					ctl_done_r <= 1'b1;
				end
				if (wr_r && ctl_r == HCTL_ADDR) begin
					addr_done_r <= 1'b1;
				end
			end
		end
	end

	assign link.host_o = out_r;
	assign link.host_oe = oe_r;
	assign busy_o = (state_r != HS_IDLE);
	assign done_o = done_r;
	assign refused_o = refused_r;
	assign ready_o = ctl_done_r && addr_done_r;
	assign rd_data_o = rd_r;

endmodule

// ==== core/hpm_link_if.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// pin link between the port device and the external host
// ------------------------------------------------------------
interface hpm_link_if;
	import hpm_pkg::*;

	logic [PIN_N-1:0] dev_o;
	logic [PIN_N-1:0] dev_oe;
	logic [PIN_N-1:0] host_o;
	logic [PIN_N-1:0] host_oe;
	logic [PIN_N-1:0] pin;

	// resolved pin level, device wins a clash, undriven pins pull high
	assign pin = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);

	modport dev (input pin, output dev_o, output dev_oe);
	modport host (input pin, output host_o, output host_oe);

endinterface

// ==== core/hpm_pkg.sv ====
package hpm_pkg;

	// ------------------------------------------------------------
	// pin vector layout on the link
	// ------------------------------------------------------------
	localparam int PIN_N = 55;
	localparam int CTL_LSB = 0;
	localparam int CTL_W = 2;
	localparam int STB_BIT = 2;
	localparam int BE_LSB = 3;
	localparam int BE_W = 4;
	localparam int DAT_LSB = 7;
	localparam int DAT_W = 32;
	localparam int ADR_LSB = 39;
	localparam int ADR_W = 16;
	localparam int PAGE_W = 8;

	// ------------------------------------------------------------
	// gpio enable groups, one enable bit per group
	// ------------------------------------------------------------
	localparam int GRP_N = 9;
	localparam int GRP_CTL = 0;
	localparam int GRP_STROBE = 1;
	localparam int GRP_BE = 2;
	localparam int GRP_DAT0 = 3;
	localparam int GRP_ADR0 = 7;
	localparam int GRP_PINS = 8;

	// ------------------------------------------------------------
	// masks and values seen by the host interface
	// ------------------------------------------------------------
	localparam logic [PIN_N-1:0] HIF_DEFAULT = {{(PIN_N-3){1'b0}}, 3'h7};
	localparam logic [PIN_N-1:0] OPT_MASK = {{(PIN_N-DAT_LSB){1'b0}}, {DAT_LSB{1'b1}}};
	localparam logic [PIN_N-1:0] ADR_MASK = {{ADR_W{1'b1}}, {ADR_LSB{1'b0}}};
	localparam logic [PIN_N-1:0] DAT_MASK = {{ADR_W{1'b0}}, {DAT_W{1'b1}}, {DAT_LSB{1'b0}}};
	localparam logic [PIN_N-1:0] PIN_RESET = '0;
	localparam logic [PAGE_W-1:0] PAGE_RESET = '0;

	// ------------------------------------------------------------
	// host register select codes
	// ------------------------------------------------------------
	localparam logic [CTL_W-1:0] HCTL_CTRL = 2'h0;
	localparam logic [CTL_W-1:0] HCTL_DATA_INC = 2'h1;
	localparam logic [CTL_W-1:0] HCTL_ADDR = 2'h2;
	localparam logic [CTL_W-1:0] HCTL_DATA = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int STROBE_NS = 40;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] STROBE_LAST = 3'(STROBE_CYC - 1);

endpackage

// ==== tb/host_port_pin_mux_gpio_tb.sv ====
`timescale 1ns/10ps
module host_port_pin_mux_gpio_tb;
	import hpm_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	typedef struct packed {logic [5:0] idx; logic dir; logic wval; logic exp;} hpm_row_s;
	localparam int TIMEOUT_CYC = 3000;
	logic core_clk_i = 1'b0, reset_n_i = 1'b0, port_enable_bit_i = 1'b0;
	logic byte_addressing_bit_i = 1'b0, nonmuxed_mode_bit_i = 1'b0, page_restrict_bit_i = 1'b0;
	logic port_soft_reset_i = 1'b1, strobe_event_enable_i = 1'b0, strobe_event_invert_i = 1'b0;
	logic hif_rd_drive_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0;
	logic [PAGE_W-1:0] page_addr_high_byte_i = 8'h00, page_addr_upper_byte_i = 8'h00;
	logic [GRP_N-1:0] gp_enable_i = '0;
	logic [PIN_N-1:0] pin_direction_i = '0, pin_data_wr_i = '0, pin_data_wdata_i = '0;
	logic [DAT_W-1:0] hif_rd_data_i = 32'h0, req_wdata_i = 32'h0, rd_data_o;
	logic [CTL_W-1:0] req_ctl_i = 2'h0;
	logic [BE_W-1:0] req_be_i = 4'hf;
	logic [ADR_W-1:0] req_addr_i = 16'h0;
	logic [PIN_N-1:0] pin_data_value_o, hif_pins_o;
	logic hif_active_o, hif_byte_addr_o, hif_nonmux_o, hif_page_restrict_o, cfg_error_o;
	logic cpu_irq_line_six_o, dma_event_o, busy_o, done_o, refused_o, ready_o;
	logic [2*PAGE_W-1:0] hif_page_o;
	int bad_count = 0, checks_done = 0, cycles = 0;
	hpm_row_s rows [9] = '{'{6'h02, 1'b1, 1'b0, 1'b0}, '{6'h02, 1'b1, 1'b1, 1'b1},
		'{6'h00, 1'b1, 1'b0, 1'b0}, '{6'h06, 1'b1, 1'b0, 1'b0}, '{6'h07, 1'b0, 1'b0, 1'b1},
		'{6'h26, 1'b1, 1'b0, 1'b0}, '{6'h27, 1'b0, 1'b0, 1'b1}, '{6'h36, 1'b1, 1'b0, 1'b0},
		'{6'h03, 1'b0, 1'b0, 1'b1}};

	// ------------------------------------------------------------
	// both ends, the link and its checker
	// ------------------------------------------------------------
	hpm_link_if u_hpm_link_if ();
	hpm_device u_hpm_device (.core_clk_i, .reset_n_i, .ce_i(1'b1), .link(u_hpm_link_if.dev),
		.port_enable_bit_i, .byte_addressing_bit_i, .nonmuxed_mode_bit_i, .page_restrict_bit_i,
		.page_addr_high_byte_i, .page_addr_upper_byte_i, .port_soft_reset_i, .gp_enable_i,
		.pin_direction_i, .pin_data_wr_i, .pin_data_wdata_i, .strobe_event_enable_i,
		.strobe_event_invert_i, .hif_rd_drive_i, .hif_rd_data_i, .pin_data_value_o, .hif_pins_o,
		.hif_active_o, .hif_byte_addr_o, .hif_nonmux_o, .hif_page_restrict_o, .hif_page_o,
		.cfg_error_o, .cpu_irq_line_six_o, .dma_event_o);
	hpm_host u_hpm_host (.core_clk_i, .reset_n_i, .ce_i(1'b1), .link(u_hpm_link_if.host),
		.req_i, .req_write_i, .req_ctl_i, .req_be_i, .req_wdata_i, .req_addr_i, .busy_o,
		.done_o, .refused_o, .ready_o, .rd_data_o);
	hpm_link_props u_hpm_link_props (.core_clk_i, .reset_n_i, .dev_o(u_hpm_link_if.dev_o),
		.dev_oe(u_hpm_link_if.dev_oe), .pin(u_hpm_link_if.pin), .gp_enable_i, .pin_direction_i,
		.hif_pins_o, .strobe_event_enable_i, .cpu_irq_line_six_o, .dma_event_o);

	// clock and hang guard
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == TIMEOUT_CYC) begin
			bad_count++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic write_bit(input int idx, input logic val);
		@(posedge core_clk_i);
		pin_data_wr_i[idx] <= 1'b1;
		pin_data_wdata_i[idx] <= val;
		@(posedge core_clk_i);
		pin_data_wr_i[idx] <= 1'b0;
	endtask
	// one host access, waits for done or refusal
	task automatic host_access(input logic wr, input logic [1:0] ctl, input logic exp_ref);
		int n;
		@(posedge core_clk_i);
		req_i <= 1'b1;
		req_write_i <= wr;
		req_ctl_i <= ctl;
		@(posedge core_clk_i);
		req_i <= 1'b0;
		#1;
		n = 0;
		while (done_o !== 1'b1 && refused_o !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		check({refused_o, done_o, busy_o}, {exp_ref, !exp_ref, 1'b0});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int n, k, rises, falls;
		logic last_irq, last_dma;
		tick(7);
		check(u_hpm_link_if.dev_oe, '0);
		check(hif_pins_o, HIF_DEFAULT);
		@(posedge core_clk_i) reset_n_i <= 1'b1;
		tick(4);
		check(hif_active_o, 1'b0);
		// all pins handed to gpio while the port is off
		@(posedge core_clk_i) gp_enable_i <= '1;
		tick(4);
		check(hif_pins_o, HIF_DEFAULT);
		foreach (rows[i]) begin
			@(posedge core_clk_i) pin_direction_i[rows[i].idx] <= rows[i].dir;
			tick(4);
			write_bit(rows[i].idx, rows[i].wval);
			tick(5);
			check(pin_data_value_o[rows[i].idx], rows[i].exp);
			check(u_hpm_link_if.pin[rows[i].idx], rows[i].exp);
			check(u_hpm_link_if.dev_oe[rows[i].idx], rows[i].dir);
		end
		$display("test table done");
		// turning an input round drives its last sample
		@(posedge core_clk_i) pin_direction_i[45] <= 1'b1;
		tick(4);
		check(u_hpm_link_if.pin[45], 1'b1);
		write_bit(45, 1'b0);
		tick(4);
		check(u_hpm_link_if.pin[45], 1'b0);
		@(posedge core_clk_i) pin_direction_i[45] <= 1'b0;
		write_bit(45, 1'b0);
		tick(5);
		check(pin_data_value_o[45], 1'b1);
		@(posedge core_clk_i) pin_direction_i[45] <= 1'b1;
		tick(4);
		check(u_hpm_link_if.pin[45], 1'b1);
		$display("test turnaround done");
		// strobe as gpio input feeding the events
		@(posedge core_clk_i) pin_direction_i[STB_BIT] <= 1'b0;
		strobe_event_enable_i <= 1'b1;
		tick(8);
		check({cpu_irq_line_six_o, dma_event_o}, 2'h3);
		@(posedge core_clk_i) strobe_event_invert_i <= 1'b1;
		tick(6);
		check(cpu_irq_line_six_o, 1'b0);
		// host strobe pulse shows inverted on the events
		@(posedge core_clk_i) req_i <= 1'b1;
		req_write_i <= 1'b1;
		req_ctl_i <= HCTL_CTRL;
		@(posedge core_clk_i) req_i <= 1'b0;
		n = 0;
		k = 0;
		rises = 0;
		falls = 0;
		last_irq = 1'b0;
		last_dma = 1'b0;
		repeat (16) begin
			@(posedge core_clk_i);
			k++;
			// pin 1 turned to output while the host still holds it low
			if (k == 3) begin
				pin_direction_i[1] <= 1'b1;
			end
			#1;
			n += cpu_irq_line_six_o;
			rises += cpu_irq_line_six_o && !last_irq;
			falls += !dma_event_o && last_dma;
			last_irq = cpu_irq_line_six_o;
			last_dma = dma_event_o;
		end
		check(n, STROBE_CYC);
		check(rises, 1);
		check(falls, 1);
		check({u_hpm_link_if.dev_oe[1], u_hpm_link_if.pin[1]}, 2'h2);
		@(posedge core_clk_i) strobe_event_enable_i <= 1'b0;
		strobe_event_invert_i <= 1'b0;
		tick(6);
		check(cpu_irq_line_six_o, 1'b0);
		$display("test events done");
		// modes and page set with port off
		@(posedge core_clk_i) pin_direction_i <= '1;
		byte_addressing_bit_i <= 1'b1;
		page_restrict_bit_i <= 1'b1;
		page_addr_high_byte_i <= 8'h5a;
		page_addr_upper_byte_i <= 8'hc3;
		tick(3);
		@(posedge core_clk_i) port_enable_bit_i <= 1'b1;
		tick(5);
		check(hif_active_o, 1'b0);
		check({hif_byte_addr_o, hif_nonmux_o, hif_page_restrict_o}, 3'h5);
		check(hif_page_o, 16'hc35a);
		check(u_hpm_link_if.dev_oe & DAT_MASK, '0);
		check(u_hpm_link_if.dev_oe[39], 1'b1);
		@(posedge core_clk_i) nonmuxed_mode_bit_i <= 1'b1;
		tick(3);
		check({cfg_error_o, hif_nonmux_o}, 2'h2);
		@(posedge core_clk_i) nonmuxed_mode_bit_i <= 1'b0;
		port_soft_reset_i <= 1'b0;
		tick(4);
		check(hif_active_o, 1'b1);
		$display("test enable done");
		// host order: control, address, then data
		@(posedge core_clk_i) gp_enable_i <= '0;
		pin_direction_i <= '0;
		req_addr_i <= 16'h1234;
		tick(4);
		host_access(1'b0, HCTL_DATA, 1'b1);
		host_access(1'b1, HCTL_ADDR, 1'b0);
		check(ready_o, 1'b1);
		@(posedge core_clk_i) hif_rd_drive_i <= 1'b1;
		hif_rd_data_i <= 32'ha5c30f96;
		host_access(1'b0, HCTL_DATA_INC, 1'b0);
		check(rd_data_o, 32'ha5c30f96);
		@(posedge core_clk_i) hif_rd_drive_i <= 1'b0;
		$display("test host done");
		// second reset in mid-run
		@(posedge core_clk_i) reset_n_i <= 1'b0;
		tick(3);
		check(u_hpm_link_if.dev_oe, '0);
		check({hif_active_o, hif_pins_o}, {1'b0, HIF_DEFAULT});
		@(posedge core_clk_i) reset_n_i <= 1'b1;
		tick(4);
		check({ready_o, busy_o}, 2'h0);
		$display("test reset done");
		complete_run();
	end
endmodule

// ==== tb/hpm_link_props.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// checker beside the pin link
// ------------------------------------------------------------
module hpm_link_props (
	input wire logic core_clk_i, // core clock
	input wire logic reset_n_i, // sync reset, active low
	input wire logic [hpm_pkg::PIN_N-1:0] dev_o, // device drive
	input wire logic [hpm_pkg::PIN_N-1:0] dev_oe, // device drive enable
	input wire logic [hpm_pkg::PIN_N-1:0] pin, // resolved pin level
	input wire logic [hpm_pkg::GRP_N-1:0] gp_enable_i, // gpio group enables
	input wire logic [hpm_pkg::PIN_N-1:0] pin_direction_i, // pin directions
	input wire logic [hpm_pkg::PIN_N-1:0] hif_pins_o, // host logic pin view
	input wire logic strobe_event_enable_i, // event gate
	input wire logic cpu_irq_line_six_o, // cpu interrupt level
	input wire logic dma_event_o // dma event level
);
	import hpm_pkg::*;

	default clocking cb @(posedge core_clk_i);
	endclocking

	// strobe pin held in one gpio setting for three cycles
	sequence s_strobe_out;
		(gp_enable_i[GRP_STROBE] && pin_direction_i[STB_BIT]) [*3];
	endsequence
	sequence s_strobe_in;
		(gp_enable_i[GRP_STROBE] && !pin_direction_i[STB_BIT]) [*3];
	endsequence
	// host pulls the strobe low while it keeps its host function
	sequence s_host_strobe_low;
		(!gp_enable_i[GRP_STROBE] && !pin[STB_BIT]) [*4];
	endsequence

	a_reset_no_drive: assert property (!reset_n_i |=> dev_oe == '0)
		else $error("device drives pins after reset");
	a_strobe_const: assert property (disable iff (!reset_n_i)
		gp_enable_i[GRP_STROBE] [*3] |=> hif_pins_o[STB_BIT]) else $error("strobe view not one");
	a_ctl_default: assert property (disable iff (!reset_n_i)
		gp_enable_i[GRP_CTL] [*3] |=> hif_pins_o[1:0] == 2'h3) else $error("ctl view not 11");
	a_be_default: assert property (disable iff (!reset_n_i)
		gp_enable_i[GRP_BE] [*3] |=> hif_pins_o[6:3] == 4'h0) else $error("be view not 0");
	a_output_drives: assert property (disable iff (!reset_n_i)
		s_strobe_out |=> dev_oe[STB_BIT] && pin[STB_BIT] == dev_o[STB_BIT])
		else $error("strobe output not driven");
	a_input_released: assert property (disable iff (!reset_n_i)
		s_strobe_in |=> !dev_oe[STB_BIT]) else $error("strobe input driven");
	a_host_strobe_seen: assert property (disable iff (!reset_n_i)
		s_host_strobe_low |=> !hif_pins_o[STB_BIT]) else $error("host strobe not seen");
	a_events_paired: assert property (disable iff (!reset_n_i)
		cpu_irq_line_six_o == dma_event_o) else $error("irq and dma differ");
	a_event_source: assert property (disable iff (!reset_n_i)
		(!gp_enable_i[GRP_STROBE] || pin_direction_i[STB_BIT]) |=> !cpu_irq_line_six_o)
		else $error("irq without strobe input");
	a_event_gated: assert property (disable iff (!reset_n_i)
		!strobe_event_enable_i [*6] |=> !cpu_irq_line_six_o) else $error("irq while gated");
endmodule
